// File: trpt_pkg.sv
// trpt_pkg: shared constants and carriers for the trace output pointer block
package trpt_pkg;
	localparam int          TRPT_DW         = 64;
	// physical address width of this part; plain default
	localparam int          TRPT_MAXPA      = 48;
	localparam int          TRPT_MATCH_LO   = 5;
	localparam int          TRPT_BASE_LO    = 7;
	localparam int          TRPT_TBL_ALIGN  = 12;
	localparam int          TRPT_TOFF_LO    = 7;
	localparam int          TRPT_TOFF_HI    = 31;
	localparam int          TRPT_ROFF_LO    = 32;
	localparam int          TRPT_ENTRY_SH   = 3;
	localparam logic [6:0]  TRPT_LOW_ONES   = 7'h7F;
	localparam logic [63:0] TRPT_BASE_RST   = 64'h0;
	localparam logic [63:0] TRPT_PTR_RST    = 64'h7F;
	localparam logic [63:0] TRPT_MATCH_RST  = 64'h0;

	// register select codes on the model-register port
	typedef enum logic [1:0] {
		TRPT_SEL_MATCH = 2'h0,
		TRPT_SEL_BASE  = 2'h1,
		TRPT_SEL_PTRS  = 2'h2,
		TRPT_SEL_NONE  = 2'h3
	} trpt_sel_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		trpt_sel_t   sel;
		logic [63:0] wdata;
	} trpt_req_t;

	// progress reported by the packet writer while tracing
	typedef struct packed {
		logic        byte_adv;
		logic [7:0]  byte_cnt;
		logic        entry_next;
		logic        table_jump;
		logic [63:0] jump_base;
	} trpt_adv_t;
endpackage

// File: trpt_check.sv
// trpt_check: address-space match and start-of-trace error checks
module trpt_check
	import trpt_pkg::*;
(
	input  wire logic [63:0] page_table_root,
	input  wire logic [63:0] match_val,
	input  wire logic [63:0] base_val,
	input  wire logic [63:0] ptr_val,
	input  wire logic [63:0] entry_region_size,
	input  wire logic        table_output_mode,
	output logic             root_match,
	output logic             start_error
);
	logic [31:0] mask_val;
	logic        align_err;
	logic        tbl_err;
	logic        off_err;

	always_comb begin
		// low five bits never take part in the comparison
		root_match = (page_table_root[63:TRPT_MATCH_LO] ==
			match_val[63:TRPT_MATCH_LO]);
		mask_val   = ptr_val[31:0];
		align_err  = |(mask_val & base_val[31:0]);
		tbl_err    = |base_val[TRPT_TBL_ALIGN-1:TRPT_BASE_LO];
		off_err    = ({32'h0, ptr_val[63:TRPT_ROFF_LO]} >=
			entry_region_size);
		start_error = table_output_mode ? (tbl_err | off_err) : align_err;
	end
endmodule // trpt_check

// File: trpt_regs.sv
// trpt_regs: match, output base and output pointer registers of trace unit
// Functional notes
// - with filter on, context allowed only while root register matches
// - match compares bits 63:5 only, low five bits ignored
// - writes to the three registers fault while trace is on
// - writing nonzero bits 4:0 of match register faults
// - base field spans bit 7 to width-1; other bits reserved zero
// - base and pointers update autonomously while tracing
// - table mode 0: base starts one contiguous output region
// - single region: mask ones overlapping base ones is operational error
// - table mode 1: nonzero base bits 11:7 error at trace start
// - pointer bits 6:0 read ones, reset 7F, writes ignored
// - pointer bits 31:7 hold table entry offset bits 27:3
// - output tables up to 256 MBytes via offset field width
// - pointer bits 63:32 byte offset added to region base
// - byte offset not below entry size at start is operational error
// - operational error sets flag, clears trigger, stops packets
module trpt_regs
	import trpt_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire trpt_req_t   req,
	input  wire trpt_adv_t   adv,
	input  wire logic        trace_on_bit,
	input  wire logic        address_space_filter_enable,
	input  wire logic        table_output_mode,
	input  wire logic        ctx_other_ok,
	input  wire logic [63:0] page_table_root,
	input  wire logic [63:0] entry_region_base,
	input  wire logic [63:0] entry_region_size,
	input  wire logic        err_clear,
	output logic      [63:0] rd_data_r,
	output logic             fault_r,
	output logic             context_allowed_r,
	output logic             trigger_on_r,
	output logic             op_error_r,
	output logic      [63:0] write_addr_r,
	output logic      [63:0] entry_addr_r
);
	localparam logic [63:0] BASE_KEEP =
		((64'h1 << TRPT_MAXPA) - 64'h1) & ~((64'h1 << TRPT_BASE_LO) - 64'h1);

	logic [63:0] match_r, match_nxt;
	logic [63:0] base_r, base_nxt;
	logic [63:0] ptr_r, ptr_nxt;
	logic [63:0] rd_data_nxt;
	logic        fault_nxt;
	logic        ctx_nxt;
	logic        trig_nxt;
	logic        err_nxt;
	logic [63:0] waddr_nxt;
	logic [63:0] eaddr_nxt;
	logic        trace_d_r;
	logic        root_match;
	logic        start_error;
	logic        trace_start;
	logic [31:0] roff_sum;
	logic [24:0] toff_sum;

	trpt_check u_check (
		.page_table_root   (page_table_root),
		.match_val         (match_r),
		.base_val          (base_r),
		.ptr_val           (ptr_r),
		.entry_region_size (entry_region_size),
		.table_output_mode (table_output_mode),
		.root_match        (root_match),
		.start_error       (start_error)
	);

	always_comb begin
		match_nxt   = match_r;
		base_nxt    = base_r;
		ptr_nxt     = ptr_r;
		fault_nxt   = 1'b0;
		rd_data_nxt = rd_data_r;
		err_nxt     = op_error_r;
		trace_start = trace_on_bit & ~trace_d_r;
		roff_sum    = ptr_r[63:TRPT_ROFF_LO] + {24'h0, adv.byte_cnt};
		toff_sum    = ptr_r[TRPT_TOFF_HI:TRPT_TOFF_LO] + 25'h1;

		if (req.wr) begin
			if (trace_on_bit) begin
				fault_nxt = 1'b1;
			end else begin
				unique case (req.sel)
					TRPT_SEL_MATCH: begin
						if (|req.wdata[TRPT_MATCH_LO-1:0])
							fault_nxt = 1'b1;
						else
							match_nxt = req.wdata;
					end
					TRPT_SEL_BASE: begin
						// reserved bits fault rather than silently drop
						if (|(req.wdata & ~BASE_KEEP))
							fault_nxt = 1'b1;
						else
							base_nxt = req.wdata;
					end
					TRPT_SEL_PTRS: begin
						ptr_nxt = {req.wdata[63:TRPT_BASE_LO],
							TRPT_LOW_ONES};
					end
					TRPT_SEL_NONE: begin
						fault_nxt = 1'b1;
					end
				endcase
			end
		end else if (trace_on_bit && !op_error_r) begin
			// hardware-owned updates; software sees stable values once off
			if (adv.table_jump && table_output_mode) begin
				base_nxt = adv.jump_base & BASE_KEEP;
				ptr_nxt  = TRPT_PTR_RST;
			end else if (adv.entry_next && table_output_mode) begin
				// 25-bit field limits tables to 256 MBytes, wraps at top
				ptr_nxt = {32'h0, toff_sum, TRPT_LOW_ONES};
			end else if (adv.byte_adv) begin
				if (table_output_mode)
					ptr_nxt[63:TRPT_ROFF_LO] = roff_sum;
				else
					ptr_nxt[63:TRPT_ROFF_LO] = roff_sum & ptr_r[31:0];
			end
		end

		if (req.rd) begin
			unique case (req.sel)
				TRPT_SEL_MATCH: rd_data_nxt = match_r;
				TRPT_SEL_BASE:  rd_data_nxt = base_r;
				TRPT_SEL_PTRS:  rd_data_nxt = {ptr_r[63:TRPT_BASE_LO],
					TRPT_LOW_ONES};
				TRPT_SEL_NONE:  rd_data_nxt = 64'h0;
			endcase
		end

		// clear only while tracing is off; a new error wins over the clear
		if (err_clear && !trace_on_bit)
			err_nxt = 1'b0;
		if (trace_start && start_error)
			err_nxt = 1'b1;

		trig_nxt = trace_on_bit & ~err_nxt;
		if (address_space_filter_enable)
			ctx_nxt = trace_on_bit & ctx_other_ok & root_match;
		else
			ctx_nxt = trace_on_bit & ctx_other_ok;

		eaddr_nxt = base_nxt + {36'h0, ptr_nxt[TRPT_TOFF_HI:TRPT_TOFF_LO],
			3'h0};
		if (table_output_mode)
			waddr_nxt = entry_region_base +
				{32'h0, ptr_nxt[63:TRPT_ROFF_LO]};
		else
			waddr_nxt = base_nxt +
				{32'h0, ptr_nxt[63:TRPT_ROFF_LO]};
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			match_r           <= TRPT_MATCH_RST;
			base_r            <= TRPT_BASE_RST;
			ptr_r             <= TRPT_PTR_RST;
			rd_data_r         <= 64'h0;
			fault_r           <= 1'b0;
			context_allowed_r <= 1'b0;
			trigger_on_r      <= 1'b0;
			op_error_r        <= 1'b0;
			write_addr_r      <= 64'h0;
			entry_addr_r      <= 64'h0;
			trace_d_r         <= 1'b0;
		end else begin
			match_r           <= match_nxt;
			base_r            <= base_nxt;
			ptr_r             <= ptr_nxt;
			rd_data_r         <= rd_data_nxt;
			fault_r           <= fault_nxt;
			context_allowed_r <= ctx_nxt;
			trigger_on_r      <= trig_nxt;
			op_error_r        <= err_nxt;
			write_addr_r      <= waddr_nxt;
			entry_addr_r      <= eaddr_nxt;
			trace_d_r         <= trace_on_bit;
		end
	end
endmodule // trpt_regs

// File: trpt_regs_properties.sv
// trpt_regs_props: port assertions for the trace pointer registers
module trpt_regs_props
	import trpt_pkg::*;
(
	input wire logic        mclk,
	input wire logic        arst_n,
	input wire trpt_req_t   req,
	input wire logic        trace_on_bit,
	input wire logic        address_space_filter_enable,
	input wire logic        ctx_other_ok,
	input wire logic [63:0] rd_data_r,
	input wire logic        fault_r,
	input wire logic        context_allowed_r,
	input wire logic        trigger_on_r,
	input wire logic        op_error_r,
	input wire logic [63:0] write_addr_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	a_busy_wr_fault: assert property (
		req.wr && trace_on_bit |=> fault_r) else $error("no fault");
	a_read_no_fault: assert property (
		req.rd && !req.wr |=> !fault_r) else $error("read faulted");
	a_match_low_fault: assert property (
		req.wr && req.sel == TRPT_SEL_MATCH && req.wdata[4:0] != 5'h0
		|=> fault_r) else $error("match low bits kept");
	a_base_low_fault: assert property (
		req.wr && req.sel == TRPT_SEL_BASE && req.wdata[6:0] != 7'h0
		|=> fault_r) else $error("base low bits kept");
	a_ptr_low_ones: assert property (
		req.rd && req.sel == TRPT_SEL_PTRS |=> rd_data_r[6:0] == TRPT_LOW_ONES)
		else $error("pointer low bits");
	a_err_trig_off: assert property (
		op_error_r |=> !trigger_on_r) else $error("trigger with error");
	a_err_sticky: assert property (
		op_error_r && trace_on_bit |=> op_error_r) else $error("error lost");
	a_filter_off_ctx: assert property (
		trace_on_bit && ctx_other_ok && !address_space_filter_enable
		|=> context_allowed_r) else $error("context gated");
	a_idle_addr_hold: assert property (
		!trace_on_bit && !$past(trace_on_bit) && !req.wr && !$past(req.wr)
		|=> $stable(write_addr_r)) else $error("address moved idle");
	c_fault: cover property (fault_r);
	c_error: cover property (op_error_r);
	c_context: cover property (context_allowed_r);
endmodule // trpt_regs_props

// File: trpt_regs_bench.sv
// trpt_regs_bench: self-checking bench for the trace pointer registers
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module trpt_regs_bench import trpt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        mclk, arst_n, tr_on, filt, tmode, ctx_ok, eclr;
	logic        fault_r, ctx_r, trig_r, err_r;
	trpt_req_t   req;
	trpt_adv_t   adv;
	logic [63:0] root, rdat, waddr, eaddr, got, d, v, msk, m;
	logic [31:0] lfsr;
	int          failures = 0, n_tests = 0, cyc = 0;
	logic [63:0] tb [5] = '{64'h1000, 64'h1080, 64'h2080, 64'h3000, 64'h3000};
	logic [63:0] tp [5] = '{64'hF80, 64'hF80, 64'h0, 64'h100_0000_0100,
		64'h8_0000_0100};
	logic        tm [5] = '{0, 0, 1, 1, 1};
	logic        te [5] = '{0, 1, 1, 1, 0};
	trpt_regs dut_u (.mclk(mclk), .arst_n(arst_n), .req(req), .adv(adv),
		.trace_on_bit(tr_on), .address_space_filter_enable(filt),
		.table_output_mode(tmode), .ctx_other_ok(ctx_ok),
		.page_table_root(root), .entry_region_base(64'h8000),
		.entry_region_size(64'h100), .err_clear(eclr), .rd_data_r(rdat),
		.fault_r(fault_r), .context_allowed_r(ctx_r), .trigger_on_r(trig_r),
		.op_error_r(err_r), .write_addr_r(waddr), .entry_addr_r(eaddr));
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task wrap_up;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task acc(input logic w, input trpt_sel_t s, input logic [63:0] x);
		@(posedge mclk) #1;
		req = '{wr: w, rd: !w, sel: s, wdata: x};
		@(posedge mclk) #1;
		req = '0;
		got = rdat;
	endtask
	task ctx(input logic f, input logic [63:0] r, input logic e);
		filt = f;
		root = r;
		repeat (2) @(posedge mclk);
		#1 `CHK(ctx_r, e)
	endtask
	initial begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			wrap_up;
		end
	end
	initial begin
		{tr_on, filt, tmode, eclr, arst_n} = '0;
		ctx_ok = 1;
		req = '0;
		adv = '0;
		root = '0;
		m = '0;
		lfsr = 32'hB13D;
		repeat (3) @(posedge mclk);
		#1 arst_n = 1;
		acc(0, TRPT_SEL_PTRS, '0); `CHK(got, TRPT_PTR_RST)
		acc(0, TRPT_SEL_BASE, '0); `CHK(got, TRPT_BASE_RST)
		$display("reset values done");
		for (int i = 0; i < 12; i++) begin
			lfsr = nxt(nxt(lfsr));
			d = {lfsr, nxt(lfsr)};
			msk = (i % 3 == 0) ? 64'hFFFF_FFFF_FFFF_FFE0 :
				(i % 3 == 1) ? 64'h0000_FFFF_FFFF_FF80 : '1;
			v = d & msk;
			if (i % 3 == 0)
				m = v;
			acc(1, trpt_sel_t'(i % 3), v); `CHK(fault_r, 1'b0)
			acc(0, trpt_sel_t'(i % 3), '0);
			`CHK(got, v | (i % 3 == 2 ? 64'h7F : 64'h0))
		end
		acc(1, TRPT_SEL_MATCH, m | 64'h1); `CHK(fault_r, 1'b1)
		acc(1, TRPT_SEL_BASE, 64'h1_0000_0000_0000); `CHK(fault_r, 1'b1)
		acc(0, TRPT_SEL_MATCH, '0); `CHK(got, m)
		$display("register access done");
		for (int k = 0; k < 5; k++) begin
			// the error flag is sticky, so each row starts idle and cleared
			tr_on = 0;
			eclr = 1;
			repeat (2) @(posedge mclk);
			#1 eclr = 0;
			acc(1, TRPT_SEL_BASE, tb[k]);
			acc(1, TRPT_SEL_PTRS, tp[k]);
			tmode = tm[k];
			tr_on = 1;
			repeat (3) @(posedge mclk);
			#1 `CHK(err_r, te[k])
			`CHK(trig_r, !te[k])
		end
		@(posedge mclk) #1 adv = '{1'b1, 8'h4, 1'b0, 1'b0, 64'h0};
		@(posedge mclk) #1 adv = '0;
		`CHK(waddr, 64'h800C)
		`CHK(eaddr, 64'h3010)
		@(posedge mclk) #1 adv = '{1'b0, 8'h0, 1'b1, 1'b0, 64'h0};
		@(posedge mclk) #1 adv = '0;
		`CHK(eaddr, 64'h3018)
		`CHK(waddr, 64'h8000)
		@(posedge mclk) #1 adv = '{1'b0, 8'h0, 1'b0, 1'b1, 64'h5000};
		@(posedge mclk) #1 adv = '0;
		`CHK(eaddr, 64'h5000)
		acc(1, TRPT_SEL_BASE, 64'h4000); `CHK(fault_r, 1'b1)
		acc(0, TRPT_SEL_BASE, '0); `CHK(got, 64'h5000)
		$display("trace start done");
		ctx(1, m | 64'h1F, 1);
		ctx(1, m ^ 64'h20, 0);
		ctx(0, m ^ 64'h20, 1);
		$display("context filter done");
		wrap_up;
	end
endmodule // trpt_regs_bench
bind trpt_regs trpt_regs_props u_props (.mclk, .arst_n, .req, .trace_on_bit,
	.address_space_filter_enable, .ctx_other_ok, .rd_data_r, .fault_r,
	.context_allowed_r, .trigger_on_r, .op_error_r, .write_addr_r);
